// ==== logic/dpm_defines.svh ====
// Functional notes
// R1: Reset holds every pad as high-impedance input
// R2: Pull-up separate from function, enabled after reset
// R3: GPIO role: input or output, pull-up optional
// R4: Owning peripheral overrides GPIO direction
// R5: Sleep freezes pad direction and output level
// R6: Enabled input pads raise wake event in sleep
// R7: Analogue use needs input with pull-up off; code forces input only, pull-up follows PULLUP_EN_IN
// R8: Pin 9: GPIO, capture, crystal, UART B, clock
// R9: Pin 10: GPIO, timer0 PWM, crystal output
// R10: Pin 11: GPIO, PWM one, UART B transmit
// R11: Pin 12: GPIO, PWM_CHANNEL_TWO, CTS, TCK, antenna, SPI
// R12: Pin 13: GPIO, PWM_CHANNEL_THREE, RTS, TMS, antenna, SPI
// R13: Pin 14: GPIO, two-wire, UART, TDO, SPI selects
// R14: Pin 15: GPIO, two-wire, UART, TDI, SPI
// R15: Pin 16: GPIO, comparator plus, two-wire, SPI
// R16: Pin 17: GPIO, comparator minus, two-wire, SPI
// R17: SPI master on 18, 19 and output-only pins
// R18: Fixed priority resolves pad conflicts
`ifndef DPM_DEFINES_SVH
`define DPM_DEFINES_SVH

`define DPM_PIN_W 20
`define DPM_OUT_ONLY_W 2
`define DPM_PAD_OE_RESET 20'h00000
`define DPM_PAD_OUT_RESET 20'h00000
`define DPM_PULLUP_RESET 20'hfffff
`define DPM_OUT_ONLY_RESET 2'h0
`define DPM_IDLE_HIGH 1'h1
`define DPM_IDLE_LOW 1'h0

`endif

// ==== logic/dpm_pkg.sv ====
package dpm_pkg;

   // Software enables of each peripheral function
   typedef struct packed {
      logic timer0_capture;
      logic timer0_pwm;
      logic slow_crystal;
      logic slow_clock_ext;
      logic uart_a;
      logic uart_a_flow;
      logic uart_b;
      logic uart_b_alt;
      logic pwm_one;
      logic pwm_two;
      logic pwm_two_alt;
      logic pwm_three;
      logic pwm_three_alt;
      logic jtag;
      logic antenna;
      logic spi_slave;
      logic spi_slave_alt;
      logic spi_master;
      logic spi_master_sel1;
      logic spi_master_sel2;
      logic two_wire;
      logic two_wire_alt;
      logic comparator;
   } dpm_periph_en_t;

   // Levels that peripherals drive towards the pads
   typedef struct packed {
      logic timer0_pwm_out;
      logic pwm_channel_one;
      logic pwm_channel_two;
      logic pwm_channel_three;
      logic uart_a_transmit;
      logic uart_a_request_to_send;
      logic uart_b_transmit;
      logic jtag_tdo;
      logic antenna_select_odd;
      logic antenna_select_even;
      logic spi_slave_data_out;
      logic spi_master_select_0;
      logic spi_master_select_1;
      logic spi_master_select_2;
      logic spi_master_data_out;
      logic spi_master_clock_out;
      logic two_wire_clock_low;
      logic two_wire_data_low;
   } dpm_periph_drive_t;

   // Pad levels handed to peripherals
   typedef struct packed {
      logic timer0_capture_in;
      logic slow_crystal_in;
      logic slow_clock_in;
      logic uart_a_receive;
      logic uart_a_clear_to_send;
      logic uart_b_receive;
      logic jtag_tck;
      logic jtag_tms;
      logic jtag_tdi;
      logic spi_slave_data_in;
      logic spi_slave_select_in;
      logic spi_slave_clock_in;
      logic spi_master_data_in;
      logic two_wire_clock;
      logic two_wire_data;
   } dpm_periph_sense_t;

endpackage

// ==== logic/dpm_port.sv ====
`timescale 1ns/1ps
`include "dpm_defines.svh"

module dpm_port (
   input wire logic CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic [`DPM_PIN_W-1:0] PAD_IN,
   output logic [`DPM_PIN_W-1:0] PAD_OUT,
   output logic [`DPM_PIN_W-1:0] PAD_OE_OUT,
   output logic [`DPM_PIN_W-1:0] PULLUP_EN_OUT,
   input wire logic [`DPM_OUT_ONLY_W-1:0] OUT_ONLY_PIN_IN,
   output logic [`DPM_OUT_ONLY_W-1:0] OUT_ONLY_PIN_OUT,
   output logic [`DPM_OUT_ONLY_W-1:0] OUT_ONLY_OE_OUT,
   input wire logic [`DPM_PIN_W-1:0] GPIO_DIR_OUT_IN,
   input wire logic [`DPM_PIN_W-1:0] GPIO_DATA_IN,
   input wire logic [`DPM_PIN_W-1:0] PULLUP_EN_IN,
   output logic [`DPM_PIN_W-1:0] GPIO_READ_OUT,
   input wire logic SLEEP_IN,
   input wire logic [`DPM_PIN_W-1:0] WAKE_EN_IN,
   input wire logic [`DPM_PIN_W-1:0] WAKE_RISING_IN,
   output logic WAKE_EVENT_OUT,
   output logic [`DPM_PIN_W-1:0] WAKE_SOURCE_OUT,
   input wire dpm_pkg::dpm_periph_en_t PERIPH_EN_IN,
   input wire dpm_pkg::dpm_periph_drive_t PERIPH_DRIVE_IN,
   output dpm_pkg::dpm_periph_sense_t PERIPH_SENSE_OUT
);

   logic [`DPM_PIN_W-1:0] own;
   logic [`DPM_PIN_W-1:0] mux_oe;
   logic [`DPM_PIN_W-1:0] mux_out;
   logic [`DPM_PIN_W-1:0] pad_oe_next;
   logic [`DPM_PIN_W-1:0] pad_out_next;
   logic [`DPM_OUT_ONLY_W-1:0] oo_oe_next;
   logic [`DPM_OUT_ONLY_W-1:0] oo_out_next;
   logic [`DPM_PIN_W-1:0] pad_prev_reg;
   logic prev_valid_reg;
   logic [`DPM_PIN_W-1:0] wake_hit;
   dpm_pkg::dpm_periph_sense_t sense_next;
   dpm_pkg::dpm_periph_en_t en;
   dpm_pkg::dpm_periph_drive_t drv;

   assign en = PERIPH_EN_IN;
   assign drv = PERIPH_DRIVE_IN;

   // Pad claims, highest priority first in each chain
   always_comb begin
      own = '0;
      mux_oe = '0;
      mux_out = '0;
      // Pin 9 is input only in every alternate role
      if (en.slow_clock_ext || en.slow_crystal || (en.uart_b &&
            !en.uart_b_alt) || en.timer0_capture) begin
         own[9] = 1'h1; // see R8
      end
      // Crystal pins are analogue, so neither is driven digitally
      if (en.slow_crystal) begin
         own[10] = 1'h1; // see R9
      end else if (en.timer0_pwm) begin
         own[10] = 1'h1;
         mux_oe[10] = 1'h1;
         mux_out[10] = drv.timer0_pwm_out; // see R9
      end
      if (en.uart_b && !en.uart_b_alt) begin
         own[11] = 1'h1;
         mux_oe[11] = 1'h1;
         mux_out[11] = drv.uart_b_transmit; // see R10
      end else if (en.pwm_one) begin
         own[11] = 1'h1;
         mux_oe[11] = 1'h1;
         mux_out[11] = drv.pwm_channel_one; // see R10
      end
      if (en.jtag || (en.spi_slave && !en.spi_slave_alt) ||
            en.uart_a_flow) begin
         own[12] = 1'h1; // see R11
      end else if (en.antenna) begin
         own[12] = 1'h1;
         mux_oe[12] = 1'h1;
         mux_out[12] = drv.antenna_select_odd; // see R11
      end else if (en.pwm_two && !en.pwm_two_alt) begin
         own[12] = 1'h1;
         mux_oe[12] = 1'h1;
         mux_out[12] = drv.pwm_channel_two; // see R11
      end
      if (en.jtag) begin
         own[13] = 1'h1; // see R12
      end else if (en.spi_slave && !en.spi_slave_alt) begin
         own[13] = 1'h1;
         mux_oe[13] = 1'h1;
         mux_out[13] = drv.spi_slave_data_out; // see R12
      end else if (en.uart_a_flow) begin
         own[13] = 1'h1;
         mux_oe[13] = 1'h1;
         mux_out[13] = drv.uart_a_request_to_send; // see R12
      end else if (en.antenna) begin
         own[13] = 1'h1;
         mux_oe[13] = 1'h1;
         mux_out[13] = drv.antenna_select_even; // see R12
      end else if (en.pwm_three && !en.pwm_three_alt) begin
         own[13] = 1'h1;
         mux_oe[13] = 1'h1;
         mux_out[13] = drv.pwm_channel_three; // see R12
      end
      own[14] = 1'h1;
      mux_oe[14] = 1'h1;
      if (en.jtag) begin
         mux_out[14] = drv.jtag_tdo; // see R13
      end else if (en.spi_slave) begin
         mux_oe[14] = 1'h0; // see R13
      end else if (en.spi_master && en.spi_master_sel1) begin
         mux_out[14] = drv.spi_master_select_1; // see R13
      end else if (en.two_wire && !en.two_wire_alt) begin
         // Open drain: only ever pulls low
         mux_oe[14] = drv.two_wire_clock_low; // see R13
      end else if (en.uart_a) begin
         mux_out[14] = drv.uart_a_transmit; // see R13
      end else if (en.uart_b && en.uart_b_alt) begin
         mux_out[14] = drv.uart_b_transmit; // see R13
      end else begin
         own[14] = 1'h0;
         mux_oe[14] = 1'h0;
      end
      own[15] = 1'h1;
      if (en.jtag || en.spi_slave) begin
         mux_oe[15] = 1'h0; // see R14
      end else if (en.spi_master && en.spi_master_sel2) begin
         mux_oe[15] = 1'h1;
         mux_out[15] = drv.spi_master_select_2; // see R14
      end else if (en.two_wire && !en.two_wire_alt) begin
         mux_oe[15] = drv.two_wire_data_low; // see R14
      end else if (!(en.uart_a || (en.uart_b && en.uart_b_alt))) begin
         own[15] = 1'h0;
      end
      // Comparator pads must float; pull-up is software's job
      if (en.comparator || (en.spi_slave && en.spi_slave_alt)) begin
         own[16] = 1'h1; // see R15, R7
      end else if (en.two_wire && en.two_wire_alt) begin
         own[16] = 1'h1;
         mux_oe[16] = drv.two_wire_clock_low; // see R15
      end
      if (en.comparator) begin
         own[17] = 1'h1; // see R16, R7
      end else if (en.spi_slave && en.spi_slave_alt) begin
         own[17] = 1'h1;
         mux_oe[17] = 1'h1;
         mux_out[17] = drv.spi_slave_data_out; // see R16
      end else if (en.two_wire && en.two_wire_alt) begin
         own[17] = 1'h1;
         mux_oe[17] = drv.two_wire_data_low; // see R16
      end
      if (en.spi_master) begin
         own[18] = 1'h1;
         mux_oe[18] = 1'h1;
         mux_out[18] = drv.spi_master_data_out; // see R17
         own[19] = 1'h1;
         mux_oe[19] = 1'h1;
         mux_out[19] = drv.spi_master_select_0; // see R17
      end
   end

   // Output-only pins; unclaimed ones float
   always_comb begin
      oo_oe_next = `DPM_OUT_ONLY_RESET;
      oo_out_next = `DPM_OUT_ONLY_RESET;
      if (en.spi_master) begin
         oo_oe_next[0] = 1'h1;
         oo_out_next[0] = drv.spi_master_clock_out; // see R17
      end else if (en.pwm_two && en.pwm_two_alt) begin
         oo_oe_next[0] = 1'h1;
         oo_out_next[0] = drv.pwm_channel_two; // see R17
      end
      // Data-in on this pin is received, so it must not drive
      if (!en.spi_master && en.pwm_three && en.pwm_three_alt) begin
         oo_oe_next[1] = 1'h1;
         oo_out_next[1] = drv.pwm_channel_three; // see R17
      end
   end

   // Peripheral claim beats the GPIO direction
   assign pad_oe_next = (own & mux_oe) |
      (~own & GPIO_DIR_OUT_IN); // see R4, R3
   assign pad_out_next = (own & mux_out) |
      (~own & GPIO_DATA_IN); // see R3, R18

   // Sleep leaves the registers untouched, freezing the pads
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         PAD_OE_OUT <= `DPM_PAD_OE_RESET; // see R1
         PAD_OUT <= `DPM_PAD_OUT_RESET;
         OUT_ONLY_OE_OUT <= `DPM_OUT_ONLY_RESET;
         OUT_ONLY_PIN_OUT <= `DPM_OUT_ONLY_RESET;
      end else if (!SLEEP_IN) begin
         PAD_OE_OUT <= pad_oe_next; // see R5
         PAD_OUT <= pad_out_next;
         OUT_ONLY_OE_OUT <= oo_oe_next;
         OUT_ONLY_PIN_OUT <= oo_out_next;
      end
   end

   // Not frozen in sleep; software must keep it steady
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         PULLUP_EN_OUT <= `DPM_PULLUP_RESET; // see R2
      end else begin
         PULLUP_EN_OUT <= PULLUP_EN_IN; // see R2, R3
      end
   end

   // Input routing; unclaimed peripherals see idle levels
   always_comb begin
      sense_next = '0;
      sense_next.uart_a_receive = `DPM_IDLE_HIGH;
      sense_next.uart_b_receive = `DPM_IDLE_HIGH;
      sense_next.spi_slave_select_in = `DPM_IDLE_HIGH;
      sense_next.two_wire_clock = `DPM_IDLE_HIGH;
      sense_next.two_wire_data = `DPM_IDLE_HIGH;
      sense_next.uart_a_clear_to_send = `DPM_IDLE_LOW;
      if (en.slow_clock_ext) begin
         sense_next.slow_clock_in = PAD_IN[9]; // see R8
      end else if (en.slow_crystal) begin
         sense_next.slow_crystal_in = PAD_IN[9]; // see R8
      end else if (en.uart_b && !en.uart_b_alt) begin
         sense_next.uart_b_receive = PAD_IN[9]; // see R8
      end else if (en.timer0_capture) begin
         sense_next.timer0_capture_in = PAD_IN[9]; // see R8
      end
      if (en.jtag) begin
         sense_next.jtag_tck = PAD_IN[12]; // see R11
         sense_next.jtag_tms = PAD_IN[13]; // see R12
         sense_next.jtag_tdi = PAD_IN[15]; // see R14
      end else if (en.spi_slave && !en.spi_slave_alt) begin
         sense_next.spi_slave_data_in = PAD_IN[12]; // see R11
      end else if (en.uart_a_flow) begin
         sense_next.uart_a_clear_to_send = PAD_IN[12]; // see R11
      end
      if (!en.jtag && en.spi_slave) begin
         sense_next.spi_slave_select_in = PAD_IN[14]; // see R13
         sense_next.spi_slave_clock_in = PAD_IN[15]; // see R14
      end else if (!en.jtag && !(en.spi_master && en.spi_master_sel2)
            && en.two_wire && !en.two_wire_alt) begin
         sense_next.two_wire_data = PAD_IN[15]; // see R14
      end else if (!en.jtag && !(en.spi_master && en.spi_master_sel2)
            && en.uart_a) begin
         sense_next.uart_a_receive = PAD_IN[15]; // see R14
      end else if (!en.jtag && !(en.spi_master && en.spi_master_sel2)
            && en.uart_b && en.uart_b_alt) begin
         sense_next.uart_b_receive = PAD_IN[15]; // see R14
      end
      if (!en.jtag && !en.spi_slave && !(en.spi_master &&
            en.spi_master_sel1) && en.two_wire && !en.two_wire_alt) begin
         sense_next.two_wire_clock = PAD_IN[14]; // see R13
      end
      if (!en.comparator && en.spi_slave && en.spi_slave_alt) begin
         sense_next.spi_slave_data_in = PAD_IN[16]; // see R15
      end else if (!en.comparator && en.two_wire && en.two_wire_alt) begin
         sense_next.two_wire_clock = PAD_IN[16]; // see R15
         sense_next.two_wire_data = PAD_IN[17]; // see R16
      end
      if (en.spi_master) begin
         sense_next.spi_master_data_in = OUT_ONLY_PIN_IN[1]; // see R17
      end
   end

   // Peripherals stay off while reset is held
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         PERIPH_SENSE_OUT <= '0; // see R1
      end else begin
         PERIPH_SENSE_OUT <= sense_next;
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         GPIO_READ_OUT <= '0;
         pad_prev_reg <= '0;
         prev_valid_reg <= 1'h0;
      end else begin
         GPIO_READ_OUT <= PAD_IN;
         pad_prev_reg <= PAD_IN;
         // No edge until one real pad sample is held
         prev_valid_reg <= 1'h1;
      end
   end

   // Edge on an enabled input pad; polarity per pin
   // Reset clears prev_valid_reg, so the first sample is not an edge
   assign wake_hit = {`DPM_PIN_W{prev_valid_reg}} & WAKE_EN_IN & ~PAD_OE_OUT &
      ((WAKE_RISING_IN & PAD_IN & ~pad_prev_reg) |
       (~WAKE_RISING_IN & ~PAD_IN & pad_prev_reg)); // see R6

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         WAKE_EVENT_OUT <= 1'h0;
         WAKE_SOURCE_OUT <= '0;
      end else begin
         // One pulse per edge; a held level raises no more
         WAKE_EVENT_OUT <= SLEEP_IN && (|wake_hit); // see R6
         WAKE_SOURCE_OUT <= SLEEP_IN ? wake_hit : '0;
      end
   end

endmodule // dpm_port

// ==== bench/dpm_port_chk.sv ====
`timescale 1ns/1ps
`include "dpm_defines.svh"

module dpm_port_chk (
   input wire logic CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic [`DPM_PIN_W-1:0] PAD_IN,
   input wire logic [`DPM_PIN_W-1:0] PAD_OUT,
   input wire logic [`DPM_PIN_W-1:0] PAD_OE_OUT,
   input wire logic [`DPM_PIN_W-1:0] PULLUP_EN_OUT,
   input wire logic [`DPM_PIN_W-1:0] PULLUP_EN_IN,
   input wire logic [`DPM_OUT_ONLY_W-1:0] OUT_ONLY_PIN_OUT,
   input wire logic [`DPM_OUT_ONLY_W-1:0] OUT_ONLY_OE_OUT,
   input wire logic [`DPM_PIN_W-1:0] GPIO_DIR_OUT_IN,
   input wire logic [`DPM_PIN_W-1:0] GPIO_DATA_IN,
   input wire logic SLEEP_IN,
   input wire logic [`DPM_PIN_W-1:0] WAKE_EN_IN,
   input wire logic [`DPM_PIN_W-1:0] WAKE_RISING_IN,
   input wire logic WAKE_EVENT_OUT,
   input wire logic [`DPM_PIN_W-1:0] WAKE_SOURCE_OUT,
   input wire dpm_pkg::dpm_periph_en_t PERIPH_EN_IN,
   input wire dpm_pkg::dpm_periph_drive_t PERIPH_DRIVE_IN,
   input wire dpm_pkg::dpm_periph_sense_t PERIPH_SENSE_OUT
);
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);

   // High when the previous edge was out of reset and awake
   logic live_reg;
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN)
         live_reg <= 1'h0;
      else
         live_reg <= !SLEEP_IN;
   end

   property p_reset_quiet;
      disable iff (1'h0) !RESET_N_IN |-> PAD_OE_OUT == 20'h0 &&
         OUT_ONLY_OE_OUT == 2'h0 && PULLUP_EN_OUT == 20'hfffff;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("pads not quiet in reset");
   property p_pullup;
      $past(RESET_N_IN) |-> PULLUP_EN_OUT == $past(PULLUP_EN_IN);
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("pull-up not following its own enable");
   property p_gpio;
      live_reg |-> ((PAD_OE_OUT ^ $past(GPIO_DIR_OUT_IN)) & 20'h001ff) == 0
         && ((PAD_OUT ^ $past(GPIO_DATA_IN)) & PAD_OE_OUT & 20'h001ff) == 0;
   endproperty
   a_gpio: assert property (p_gpio)
      else $error("gpio pad direction or level wrong");
   property p_freeze;
      $past(SLEEP_IN) && $past(RESET_N_IN) |-> $stable(PAD_OE_OUT) &&
         $stable(PAD_OUT) && $stable(OUT_ONLY_OE_OUT) &&
         $stable(OUT_ONLY_PIN_OUT);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("pad state moved during sleep");
   property p_wake_sleep;
      WAKE_EVENT_OUT |-> $past(SLEEP_IN) && WAKE_SOURCE_OUT != 20'h0 &&
         (WAKE_SOURCE_OUT & ~$past(WAKE_EN_IN)) == 20'h0;
   endproperty
   a_wake_sleep: assert property (p_wake_sleep)
      else $error("wake event without sleep or enable");
   sequence s_rise5;
      $past(SLEEP_IN) && $past(WAKE_EN_IN[5]) && $past(WAKE_RISING_IN[5]) &&
         !$past(PAD_OE_OUT[5]) && $past(PAD_IN[5]) && !$past(PAD_IN[5], 2) &&
         $past(RESET_N_IN, 2);
   endsequence
   property p_wake_rise;
      s_rise5 |-> WAKE_EVENT_OUT && WAKE_SOURCE_OUT[5];
   endproperty
   a_wake_rise: assert property (p_wake_rise)
      else $error("rising edge on wake pin missed");
   property p_spi_master;
      live_reg && $past(PERIPH_EN_IN.spi_master) |-> PAD_OE_OUT[19:18] == 2'h3
         && PAD_OUT[18] == $past(PERIPH_DRIVE_IN.spi_master_data_out)
         && PAD_OUT[19] == $past(PERIPH_DRIVE_IN.spi_master_select_0)
         && OUT_ONLY_OE_OUT == 2'h1
         && OUT_ONLY_PIN_OUT[0] == $past(PERIPH_DRIVE_IN.spi_master_clock_out);
   endproperty
   a_spi_master: assert property (p_spi_master)
      else $error("spi master pins wrong");
   property p_uart_b_tx;
      live_reg && $past(PERIPH_EN_IN.uart_b) && !$past(PERIPH_EN_IN.uart_b_alt)
         |-> PAD_OE_OUT[11] &&
         PAD_OUT[11] == $past(PERIPH_DRIVE_IN.uart_b_transmit);
   endproperty
   a_uart_b_tx: assert property (p_uart_b_tx)
      else $error("pin 11 not carrying uart b transmit");
   property p_jtag;
      live_reg && $past(PERIPH_EN_IN.jtag) |-> !PAD_OE_OUT[12] &&
         PERIPH_SENSE_OUT.jtag_tck == $past(PAD_IN[12]) &&
         PERIPH_SENSE_OUT.jtag_tdi == $past(PAD_IN[15]);
   endproperty
   a_jtag: assert property (p_jtag)
      else $error("jtag inputs not routed");
   property p_two_wire;
      live_reg && $past(PERIPH_EN_IN.two_wire) &&
         $past(PERIPH_EN_IN[9:5] == 5'h0) && !$past(PERIPH_EN_IN.two_wire_alt)
         |-> PAD_OE_OUT[14] == $past(PERIPH_DRIVE_IN.two_wire_clock_low) &&
         !PAD_OUT[14];
   endproperty
   a_two_wire: assert property (p_two_wire)
      else $error("two-wire clock not open drain");

   c_wake: cover property (WAKE_EVENT_OUT);
   c_sleep: cover property (SLEEP_IN ##1 SLEEP_IN);
   c_spi: cover property (PERIPH_EN_IN.spi_master);
endmodule // dpm_port_chk

bind dpm_port dpm_port_chk u_chk (.*);

// ==== bench/dpm_pad_model.sv ====
`timescale 1ns/1ps
`include "dpm_defines.svh"

module dpm_pad_model (
   input wire logic clk_in,
   input wire logic [`DPM_PIN_W-1:0] pad_out_in,
   input wire logic [`DPM_PIN_W-1:0] pad_oe_in,
   input wire logic [`DPM_PIN_W-1:0] pullup_in,
   input wire logic [1:0] oo_out_in,
   input wire logic [1:0] oo_oe_in,
   input wire logic [21:0] ext_en_in,
   input wire logic [21:0] ext_val_in,
   output logic [`DPM_PIN_W-1:0] pad_level_out,
   output logic [1:0] oo_level_out
);
   // Floating lines wander so a stale level never passes for data
   logic flip_reg = 1'h0;
   always_ff @(posedge clk_in) begin
      flip_reg <= !flip_reg;
   end
   always_comb begin
      for (int i = 0; i < `DPM_PIN_W; i++) begin
         if (pad_oe_in[i])
            pad_level_out[i] = pad_out_in[i];
         else if (ext_en_in[i])
            pad_level_out[i] = ext_val_in[i];
         else
            pad_level_out[i] = pullup_in[i] | flip_reg;
      end
      for (int j = 0; j < 2; j++) begin
         if (oo_oe_in[j])
            oo_level_out[j] = oo_out_in[j];
         else
            oo_level_out[j] = ext_en_in[20+j] ? ext_val_in[20+j] : flip_reg;
      end
   end
endmodule // dpm_pad_model

// ==== bench/dpm_port_tb.sv ====
`timescale 1ns/1ps
`include "dpm_defines.svh"

module dpm_port_tb;
   logic clk = 1'h0;
   logic rst_n = 1'h1;
   logic sleep = 1'h0;
   logic [19:0] dir = '0, data = '0, pull_in = '1;
   logic [19:0] wake_en = '0, wake_rise = '0;
   logic [19:0] pad_in, pad_out, pad_oe, pull_out, gpio_read, wake_src;
   logic [1:0] oo_in, oo_out, oo_oe;
   logic wake_ev;
   logic [21:0] ext_en = '0, ext_val = '0, oe_all, out_all;
   dpm_pkg::dpm_periph_en_t en = '0;
   dpm_pkg::dpm_periph_drive_t drv = '0;
   dpm_pkg::dpm_periph_sense_t sense;
   int failures = 0;
   int checks = 0;
   int p;
   // Enable bit, second enable bit, pin, oe, level, sense bit
   int rows [45][6] = '{'{-1,-1,9,1,0,-1}, '{22,-1,9,0,0,14},
      '{20,-1,9,0,0,13}, '{16,-1,9,0,0,9}, '{19,-1,9,0,0,12},
      '{21,-1,10,1,1,-1}, '{20,-1,10,0,0,-1}, '{14,-1,11,1,1,-1},
      '{16,-1,11,1,1,-1}, '{13,-1,12,1,1,-1}, '{17,-1,12,0,0,10},
      '{9,-1,12,0,0,8}, '{8,-1,12,1,1,-1}, '{7,-1,12,0,0,5},
      '{11,-1,13,1,1,-1}, '{17,-1,13,1,1,-1}, '{9,-1,13,0,0,7},
      '{8,-1,13,1,1,-1}, '{7,-1,13,1,1,-1}, '{2,-1,14,1,0,-1},
      '{18,-1,14,1,1,-1}, '{16,15,14,1,1,-1}, '{9,-1,14,1,1,-1},
      '{5,4,14,1,1,-1}, '{7,-1,14,0,0,4}, '{2,-1,15,1,0,-1},
      '{18,-1,15,0,0,11}, '{16,15,15,0,0,9}, '{9,-1,15,0,0,6},
      '{5,3,15,1,1,-1}, '{7,-1,15,0,0,3}, '{0,-1,16,0,0,-1},
      '{2,1,16,1,0,-1}, '{7,6,16,0,0,5}, '{0,-1,17,0,0,-1},
      '{2,1,17,1,0,-1}, '{7,6,17,1,1,-1}, '{5,-1,18,1,1,-1},
      '{5,-1,19,1,1,-1}, '{5,-1,20,1,1,-1}, '{13,12,20,1,1,-1},
      '{5,-1,21,0,0,2}, '{11,10,21,1,1,-1}, '{9,13,12,0,0,8},
      '{2,18,14,1,0,-1}};
   assign oe_all = {oo_oe, pad_oe};
   assign out_all = {oo_out, pad_out};
   always #4 clk = ~clk;

   dpm_port dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .PAD_IN(pad_in),
      .PAD_OUT(pad_out), .PAD_OE_OUT(pad_oe), .PULLUP_EN_OUT(pull_out),
      .OUT_ONLY_PIN_IN(oo_in), .OUT_ONLY_PIN_OUT(oo_out),
      .OUT_ONLY_OE_OUT(oo_oe), .GPIO_DIR_OUT_IN(dir), .GPIO_DATA_IN(data),
      .PULLUP_EN_IN(pull_in), .GPIO_READ_OUT(gpio_read), .SLEEP_IN(sleep),
      .WAKE_EN_IN(wake_en), .WAKE_RISING_IN(wake_rise),
      .WAKE_EVENT_OUT(wake_ev), .WAKE_SOURCE_OUT(wake_src),
      .PERIPH_EN_IN(en), .PERIPH_DRIVE_IN(drv), .PERIPH_SENSE_OUT(sense));
   dpm_pad_model ext (.clk_in(clk), .pad_out_in(pad_out), .pad_oe_in(pad_oe),
      .pullup_in(pull_out), .oo_out_in(oo_out), .oo_oe_in(oo_oe),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_level_out(pad_in),
      .oo_level_out(oo_in));

   task automatic check(input string name, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results();
      if (failures == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   initial begin
      // A real falling edge, so the asynchronous reset fires
      #1;
      rst_n = 1'h0;
      tick(10);
      check("reset oe", oe_all, 22'h0);
      check("reset out", out_all, 22'h0);
      check("reset pull", pull_out, 20'hfffff);
      check("reset sense", sense, 15'h0);
      tick(10);
      rst_n = 1'h1;
      tick(2);
      foreach (rows[r]) begin
         en = '0;
         if (rows[r][0] >= 0) en[rows[r][0]] = 1'h1;
         if (rows[r][1] >= 0) en[rows[r][1]] = 1'h1;
         // Analogue use wants input with pull-up off
         dir = (rows[r][0] == 0) ? 20'h0ffff : 20'hfffff;
         pull_in = (rows[r][0] == 0) ? 20'h0ffff : 20'hfffff;
         drv = '1;
         ext_en = '1;
         ext_val = '1;
         tick(2);
         p = rows[r][2];
         check("pad oe", oe_all[p], rows[r][3]);
         if (rows[r][3]) check("pad out", out_all[p], rows[r][4]);
         if (rows[r][5] >= 0) begin
            check("sense high", sense[rows[r][5]], 1'h1);
            ext_val[p] = 1'h0;
            tick(2);
            check("sense low", sense[rows[r][5]], 1'h0);
         end
      end
      en = '0;
      ext_en = 22'h000e0;
      ext_val = 22'h00040;
      dir = 20'h00110;
      data = 20'h001a5;
      pull_in = 20'h0000f;
      wake_en = 20'h00060;
      wake_rise = 20'h00020;
      tick(3);
      check("gpio oe", pad_oe[8:0], 9'h110);
      check("gpio out", {pad_out[8], pad_out[4]}, 2'h2);
      check("pull", pull_out, 20'h0000f);
      check("pull read", gpio_read[3:0], 4'hf);
      sleep = 1'h1;
      tick(1);
      dir = 20'h0;
      data = 20'h0;
      tick(3);
      check("frozen oe", pad_oe[8:0], 9'h110);
      check("frozen out", {pad_out[8], pad_out[4]}, 2'h2);
      ext_val[5] = 1'h1;
      tick(1);
      check("wake", wake_ev, 1'h1);
      check("wake src", wake_src, 20'h00020);
      ext_val[7] = 1'h1;
      tick(1);
      check("wake off pin", wake_ev, 1'h0);
      ext_val[6] = 1'h0;
      tick(1);
      check("wake fall src", wake_src, 20'h00040);
      sleep = 1'h0;
      ext_val[6] = 1'h1;
      tick(1);
      ext_val[6] = 1'h0;
      tick(1);
      check("no wake awake", wake_ev, 1'h0);
      check("thaw oe", pad_oe[8:0], 9'h000);
      rst_n = 1'h0;
      #1;
      check("mid reset oe", oe_all, 22'h0);
      check("mid reset pull", pull_out, 20'hfffff);
      // Pin 5 sits high: a stale history would fake a rising edge
      sleep = 1'h1;
      tick(2);
      rst_n = 1'h1;
      tick(1);
      check("no wake from reset", wake_ev, 1'h0);
      check("pull after reset", pull_out, 20'h0000f);
      tick(1);
      check("still no wake", wake_ev, 1'h0);
      results();
   end

   initial begin
      #100000;
      failures++;
      results();
   end
endmodule // dpm_port_tb
